// ### fosc_pkg.sv
// Package with the register map, field positions and codes of the flash status/control block.
package fosc_pkg;

  // ********************************************************
  // Register byte addresses
  // ********************************************************
  localparam logic [7:0] MAIN_KEY_OFS   = 8'h04;
  localparam logic [7:0] USD_KEY_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS     = 8'h0c;
  localparam logic [7:0] CONTROL_OFS    = 8'h10;
  localparam logic [7:0] ERASE_ADDR_OFS = 8'h14;

  // ********************************************************
  // Status fields
  // ********************************************************
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_FAULT_BIT   = 2;
  localparam int ST_PROTECT_BIT = 4;
  localparam int ST_DONE_BIT    = 5;

  // ********************************************************
  // Control fields
  // ********************************************************
  localparam int CT_MAIN_PROG_BIT = 0;
  localparam int CT_SECTOR_BIT    = 1;
  localparam int CT_BANK_BIT      = 2;
  localparam int CT_USD_PROG_BIT  = 4;
  localparam int CT_USD_ERASE_BIT = 5;
  localparam int CT_TRIGGER_BIT   = 6;
  localparam int CT_LOCK_BIT      = 7;
  localparam int CT_UNLOCKED_BIT  = 9;
  localparam int CT_FAULT_IE_BIT  = 10;
  localparam int CT_DONE_IE_BIT   = 12;
  localparam int CT_LOW_POWER_BIT = 17;

  // ********************************************************
  // Reset values and erased word
  // ********************************************************
  localparam logic [31:0] CONTROL_RESET = 32'h0002_0080;
  localparam logic [31:0] ERASE_ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;

  // ********************************************************
  // Commands to the flash array
  // ********************************************************
  localparam logic [2:0] CMD_NONE         = 3'h0;
  localparam logic [2:0] CMD_SECTOR_ERASE = 3'h1;
  localparam logic [2:0] CMD_BANK_ERASE   = 3'h2;
  localparam logic [2:0] CMD_USD_ERASE    = 3'h3;
  localparam logic [2:0] CMD_MAIN_PROGRAM = 3'h4;
  localparam logic [2:0] CMD_USD_PROGRAM  = 3'h5;

  typedef enum logic [1:0] {
    FOSC_IDLE = 2'b01,
    FOSC_BUSY = 2'b10
  } fosc_state_e;

endpackage

// ### fosc_ctrl.sv
// Flash operation status and control register block with flash array sequencing.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - User-data key register is write-only, reads zero
// - Done flag set on completion, write-one clears
// - Protection error flag on protected main-array program, W1C
// - Program fault flag when target not erased
// - Busy flag high while operation in progress
// - Low-power enable plus deep sleep powers flash down
// - Done interrupt enable gates done interrupt
// - Error enable gates both error flags
// - Unlocked bit set by key, gates user-data ops
// - Writing zero relocks user-data area
// - Lock bit resets to one, key clears it
// - Writing one relocks erase and program
// - Erase trigger starts erase, cleared on completion
// - User-data erase select makes erase user-data erase
// - User-data program select targets user-data area
// - Bank and sector selects choose erase extent
// - Main program select makes writes program array
// - Reserved bits read zero, writes ignored
// - Main key register write-only, reads zero
module fosc_ctrl #(
  parameter logic [31:0] KEY_FIRST  = 32'h1234_5678,
  parameter logic [31:0] KEY_SECOND = 32'h9abc_def0
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata_q,
  // Program writes into the flash address space
  input  wire logic        prog_write,
  input  wire logic [31:0] prog_addr,
  input  wire logic [15:0] prog_data,
  // Flash array
  input  wire logic        array_done,
  input  wire logic        target_protected,
  input  wire logic [15:0] target_word,
  output logic             flash_start_q,
  output logic      [2:0]  flash_cmd_q,
  output logic      [31:0] flash_addr_q,
  output logic      [15:0] flash_data_q,
  output logic             flash_low_power_q,
  // System
  input  wire logic        deep_sleep,
  output logic             flash_irq_q
);

  // ********************************************************
  // Decode
  // ********************************************************
  logic              wr_status;
  logic              wr_control;
  logic              wr_main_key;
  logic              wr_usd_key;
  logic              wr_erase_addr;
  logic              done_flag_q;
  logic              protect_flag_q;
  logic              fault_flag_q;
  logic              lock_q;
  logic              unlocked_q;
  logic              trigger_q;
  logic              main_sel_q;
  logic              sector_sel_q;
  logic              bank_sel_q;
  logic              usd_prog_sel_q;
  logic              usd_erase_sel_q;
  logic              done_ie_q;
  logic              fault_ie_q;
  logic              low_power_q;
  logic              main_key_half_q;
  logic              usd_key_half_q;
  logic [31:0]       erase_addr_q;
  fosc_pkg::fosc_state_e state_q;
  logic              idle;
  logic              op_complete;
  logic              erase_go;
  logic [2:0]        erase_cmd;
  logic              prog_ok;
  logic              prog_go;
  logic              prog_protect_err;
  logic              prog_fault_err;
  logic              relock_wr;

  function automatic logic hit(input logic [7:0] ofs);
    hit = reg_write && (reg_addr == ofs);
  endfunction

  assign wr_status     = hit(fosc_pkg::STATUS_OFS);
  assign wr_control    = hit(fosc_pkg::CONTROL_OFS);
  assign wr_main_key   = hit(fosc_pkg::MAIN_KEY_OFS);
  assign wr_usd_key    = hit(fosc_pkg::USD_KEY_OFS);
  assign wr_erase_addr = hit(fosc_pkg::ERASE_ADDR_OFS);

  assign idle        = (state_q == fosc_pkg::FOSC_IDLE);
  assign op_complete = (state_q == fosc_pkg::FOSC_BUSY) && array_done;

  // ********************************************************
  // Operation launch
  // ********************************************************
  // Erase kind selection.
  // The selects written together with the trigger decide the erase, so one write may
  // both choose and start it.
  always_comb begin
    if (reg_wdata[fosc_pkg::CT_USD_ERASE_BIT]) begin
      erase_cmd = fosc_pkg::CMD_USD_ERASE;
    end else if (reg_wdata[fosc_pkg::CT_BANK_BIT]) begin
      erase_cmd = fosc_pkg::CMD_BANK_ERASE;
    end else if (reg_wdata[fosc_pkg::CT_SECTOR_BIT]) begin
      erase_cmd = fosc_pkg::CMD_SECTOR_ERASE;
    end else begin
      erase_cmd = fosc_pkg::CMD_NONE;
    end
  end

  // Erase request launches only when the block may run it.
  // A user-data erase while relocked is refused, which keeps the trigger low.
  // A relock write refuses any launch in its own cycle as well.
  assign relock_wr = wr_control && reg_wdata[fosc_pkg::CT_LOCK_BIT];
  assign erase_go = wr_control && reg_wdata[fosc_pkg::CT_TRIGGER_BIT] && idle && !lock_q &&
                    !relock_wr && (erase_cmd != fosc_pkg::CMD_NONE) &&
                    (!reg_wdata[fosc_pkg::CT_USD_ERASE_BIT] ||
                     (unlocked_q && reg_wdata[fosc_pkg::CT_UNLOCKED_BIT]));

  // Program writes count only with a program select set.
  assign prog_ok = prog_write && idle && !lock_q && !relock_wr &&
                   (main_sel_q || (usd_prog_sel_q && unlocked_q));
  assign prog_protect_err = prog_ok && main_sel_q && target_protected;
  // Target does not hold the erased value.
  assign prog_fault_err = prog_ok && !prog_protect_err && (target_word != fosc_pkg::ERASED_WORD);
  assign prog_go = prog_ok && !prog_protect_err && !prog_fault_err;

  // ********************************************************
  // Sequencer
  // ********************************************************
  // Busy from launch until the array reports completion.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= fosc_pkg::FOSC_IDLE;
    end else begin
      case (state_q)
        fosc_pkg::FOSC_IDLE: begin
          if (erase_go || prog_go) begin
            state_q <= fosc_pkg::FOSC_BUSY;
          end
        end
        fosc_pkg::FOSC_BUSY: begin
          if (array_done) begin
            state_q <= fosc_pkg::FOSC_IDLE;
          end
        end
        default: state_q <= fosc_pkg::FOSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_start_q <= 1'b0;
      flash_cmd_q   <= fosc_pkg::CMD_NONE;
      flash_addr_q  <= 32'h0000_0000;
      flash_data_q  <= 16'h0000;
    end else begin
      flash_start_q <= erase_go || prog_go;
      if (erase_go) begin
        flash_cmd_q  <= erase_cmd;
        // Erase goes to the address software stored beforehand.
        flash_addr_q <= erase_addr_q;
      end else if (prog_go) begin
        flash_cmd_q  <= main_sel_q ? fosc_pkg::CMD_MAIN_PROGRAM : fosc_pkg::CMD_USD_PROGRAM;
        flash_addr_q <= prog_addr;
        flash_data_q <= prog_data;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      erase_addr_q <= fosc_pkg::ERASE_ADDR_RESET;
    end else if (wr_erase_addr) begin
      erase_addr_q <= reg_wdata;
    end
  end

  // ********************************************************
  // Status flags
  // ********************************************************
  // Set wins over a write-one clear in the same cycle so no event is lost.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_flag_q    <= 1'b0;
      protect_flag_q <= 1'b0;
      fault_flag_q   <= 1'b0;
    end else begin
      if (op_complete) begin
        done_flag_q <= 1'b1;
      end else if (wr_status && reg_wdata[fosc_pkg::ST_DONE_BIT]) begin
        done_flag_q <= 1'b0;
      end
      if (prog_protect_err) begin
        protect_flag_q <= 1'b1;
      end else if (wr_status && reg_wdata[fosc_pkg::ST_PROTECT_BIT]) begin
        protect_flag_q <= 1'b0;
      end
      if (prog_fault_err) begin
        fault_flag_q <= 1'b1;
      end else if (wr_status && reg_wdata[fosc_pkg::ST_FAULT_BIT]) begin
        fault_flag_q <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Unlock sequences
  // ********************************************************
  // Two key words in a row unlock; any other word restarts the sequence.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_key_half_q <= 1'b0;
      usd_key_half_q  <= 1'b0;
    end else begin
      if (wr_main_key) begin
        main_key_half_q <= !main_key_half_q && (reg_wdata == KEY_FIRST);
      end
      if (wr_usd_key) begin
        usd_key_half_q <= !usd_key_half_q && (reg_wdata == KEY_FIRST);
      end
    end
  end

  // ********************************************************
  // Control register
  // ********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_q <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_LOCK_BIT];
    end else if (wr_control && reg_wdata[fosc_pkg::CT_LOCK_BIT]) begin
      lock_q <= 1'b1;
    end else if (wr_main_key && main_key_half_q && (reg_wdata == KEY_SECOND)) begin
      // Correct key pair clears the lock.
      lock_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unlocked_q <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_UNLOCKED_BIT];
    end else if (wr_control && !reg_wdata[fosc_pkg::CT_UNLOCKED_BIT]) begin
      // Writing zero relocks the user-data area.
      unlocked_q <= 1'b0;
    end else if (wr_usd_key && usd_key_half_q && (reg_wdata == KEY_SECOND)) begin
      unlocked_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trigger_q <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_TRIGGER_BIT];
    end else if (erase_go) begin
      trigger_q <= 1'b1;
    end else if (op_complete) begin
      // Cleared by hardware when the erase finishes.
      trigger_q <= 1'b0;
    end
  end

  // Selects are read/write fields frozen while busy; enables are plain read/write fields written at any time.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_sel_q      <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_MAIN_PROG_BIT];
      sector_sel_q    <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_SECTOR_BIT];
      bank_sel_q      <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_BANK_BIT];
      usd_prog_sel_q  <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_USD_PROG_BIT];
      usd_erase_sel_q <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_USD_ERASE_BIT];
      fault_ie_q      <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_FAULT_IE_BIT];
      done_ie_q       <= fosc_pkg::CONTROL_RESET[fosc_pkg::CT_DONE_IE_BIT];
      low_power_q     <= 1'b0;
    end else if (wr_control) begin
      fault_ie_q  <= reg_wdata[fosc_pkg::CT_FAULT_IE_BIT];
      done_ie_q   <= reg_wdata[fosc_pkg::CT_DONE_IE_BIT];
      low_power_q <= reg_wdata[fosc_pkg::CT_LOW_POWER_BIT];
      if (idle) begin
        main_sel_q      <= reg_wdata[fosc_pkg::CT_MAIN_PROG_BIT];
        sector_sel_q    <= reg_wdata[fosc_pkg::CT_SECTOR_BIT];
        bank_sel_q      <= reg_wdata[fosc_pkg::CT_BANK_BIT];
        usd_prog_sel_q  <= reg_wdata[fosc_pkg::CT_USD_PROG_BIT];
        usd_erase_sel_q <= reg_wdata[fosc_pkg::CT_USD_ERASE_BIT];
      end
    end
  end

  // ********************************************************
  // Outputs to the system
  // ********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_low_power_q <= 1'b0;
      flash_irq_q       <= 1'b0;
    end else begin
      // Power down only in deep sleep with the enable set.
      flash_low_power_q <= low_power_q && deep_sleep;
      flash_irq_q <= (done_flag_q && done_ie_q) ||
                     ((protect_flag_q || fault_flag_q) && fault_ie_q);
    end
  end

  // ********************************************************
  // Register read
  // ********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      // Keys, reserved bits and holes read zero.
      reg_rdata_q <= 32'h0000_0000;
      if (reg_read && (reg_addr == fosc_pkg::STATUS_OFS)) begin
        reg_rdata_q[fosc_pkg::ST_BUSY_BIT]    <= !idle;
        reg_rdata_q[fosc_pkg::ST_FAULT_BIT]   <= fault_flag_q;
        reg_rdata_q[fosc_pkg::ST_PROTECT_BIT] <= protect_flag_q;
        reg_rdata_q[fosc_pkg::ST_DONE_BIT]    <= done_flag_q;
      end else if (reg_read && (reg_addr == fosc_pkg::CONTROL_OFS)) begin
        reg_rdata_q[fosc_pkg::CT_MAIN_PROG_BIT]  <= main_sel_q;
        reg_rdata_q[fosc_pkg::CT_SECTOR_BIT]     <= sector_sel_q;
        reg_rdata_q[fosc_pkg::CT_BANK_BIT]       <= bank_sel_q;
        reg_rdata_q[fosc_pkg::CT_USD_PROG_BIT]   <= usd_prog_sel_q;
        reg_rdata_q[fosc_pkg::CT_USD_ERASE_BIT]  <= usd_erase_sel_q;
        reg_rdata_q[fosc_pkg::CT_TRIGGER_BIT]    <= trigger_q;
        reg_rdata_q[fosc_pkg::CT_LOCK_BIT]       <= lock_q;
        reg_rdata_q[fosc_pkg::CT_UNLOCKED_BIT]   <= unlocked_q;
        reg_rdata_q[fosc_pkg::CT_FAULT_IE_BIT]   <= fault_ie_q;
        reg_rdata_q[fosc_pkg::CT_DONE_IE_BIT]    <= done_ie_q;
        reg_rdata_q[fosc_pkg::CT_LOW_POWER_BIT]  <= low_power_q;
      end
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_usd_key_zero: assert property (
    reg_read && (reg_addr == fosc_pkg::USD_KEY_OFS) |=> reg_rdata_q == 32'h0000_0000)
    else $error("user-data key register read nonzero");
  a_main_key_zero: assert property (
    reg_read && (reg_addr == fosc_pkg::MAIN_KEY_OFS) |=> reg_rdata_q == 32'h0000_0000)
    else $error("main key register read nonzero");
  a_done_set: assert property (
    op_complete |=> done_flag_q)
    else $error("done flag not set on completion");
  a_done_sticky: assert property (
    done_flag_q && !(wr_status && reg_wdata[fosc_pkg::ST_DONE_BIT]) |=> done_flag_q)
    else $error("done flag cleared without write one");
  a_protect_set: assert property (
    prog_write && idle && !lock_q && !relock_wr && main_sel_q && target_protected |=>
      protect_flag_q && !flash_start_q)
    else $error("protected program not flagged");
  a_fault_set: assert property (
    prog_write && idle && !lock_q && !relock_wr && main_sel_q && !target_protected &&
      (target_word != fosc_pkg::ERASED_WORD) |=> fault_flag_q && !flash_start_q)
    else $error("program over non-erased word not flagged");
  a_busy_span: assert property (
    !idle && !op_complete |=> !idle)
    else $error("busy dropped before completion");
  a_busy_drop: assert property (
    op_complete |=> idle)
    else $error("busy not dropped after completion");
  a_low_power: assert property (
    ##1 flash_low_power_q == ($past(low_power_q) && $past(deep_sleep)))
    else $error("low power output mismatched");
  a_irq_done: assert property (
    done_flag_q && done_ie_q |=> flash_irq_q)
    else $error("done interrupt missing");
  a_irq_fault: assert property (
    (protect_flag_q || fault_flag_q) && fault_ie_q |=> flash_irq_q)
    else $error("error interrupt missing");
  a_irq_quiet: assert property (
    !done_flag_q && !protect_flag_q && !fault_flag_q |=> !flash_irq_q)
    else $error("interrupt without any flag");
  a_usd_gate: assert property (
    flash_start_q && (flash_cmd_q == fosc_pkg::CMD_USD_ERASE ||
      flash_cmd_q == fosc_pkg::CMD_USD_PROGRAM) |-> $past(unlocked_q))
    else $error("user-data operation while relocked");
  a_usd_relock: assert property (
    wr_control && !reg_wdata[fosc_pkg::CT_UNLOCKED_BIT] |=> !unlocked_q)
    else $error("user-data relock failed");
  a_lock_gate: assert property (
    flash_start_q |-> !$past(lock_q))
    else $error("operation launched while locked");
  a_relock: assert property (
    wr_control && reg_wdata[fosc_pkg::CT_LOCK_BIT] |=> lock_q && !flash_start_q)
    else $error("relock failed");
  a_trigger_clear: assert property (
    op_complete && trigger_q |=> !trigger_q)
    else $error("erase trigger not cleared");
  a_erase_kind: assert property (
    erase_go && !reg_wdata[fosc_pkg::CT_USD_ERASE_BIT] && reg_wdata[fosc_pkg::CT_BANK_BIT] |=>
      flash_cmd_q == fosc_pkg::CMD_BANK_ERASE)
    else $error("bank erase not selected");

  c_erase_done: cover property (erase_go ##[1:50] op_complete);
  c_program_done: cover property (prog_go ##[1:50] op_complete);
  c_protect_error: cover property (prog_protect_err);
  c_usd_unlock: cover property (!unlocked_q ##1 unlocked_q);

endmodule

// ### fosc_flash_model.sv
// Behavioural flash array that ends each launched operation after a set delay.
`timescale 1ns/1ps
module fosc_flash_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Launch and completion
  input  wire logic       flash_start_q,
  input  wire logic [3:0] delay,
  output logic            array_done
);
  logic [3:0] cnt_q;
  logic       run_q;
  // The bench sets the delay so that both prompt and slow arrays are seen.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_q      <= 1'b0;
      cnt_q      <= 4'h0;
      array_done <= 1'b0;
    end else begin
      array_done <= 1'b0;
      if (flash_start_q) begin
        run_q <= 1'b1;
        cnt_q <= delay;
      end else if (run_q && cnt_q == 4'h0) begin
        run_q      <= 1'b0;
        array_done <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// ### fosc_ctrl_tb.sv
// Self-checking testbench for the flash status and control block.
`timescale 1ns/1ps
module fosc_ctrl_tb;
  typedef struct packed {
    logic [2:0]  cmd;
    logic [31:0] adr;
    logic [15:0] dat;
    logic        use_d;
  } fosc_exp_s;
  // Key values are arbitrary.
  localparam logic [31:0] K1 = 32'h1357_2468;
  localparam logic [31:0] K2 = 32'h8642_7531;
  logic clock = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, prog_write = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, prog_addr = 32'h0, reg_rdata_q, flash_addr_q;
  logic [15:0] prog_data = 16'h0, target_word = 16'h0, flash_data_q;
  logic        target_protected = 1'b0, deep_sleep = 1'b0, array_done, rd_pend = 1'b0;
  logic        flash_start_q, flash_low_power_q, flash_irq_q;
  logic [2:0]  flash_cmd_q;
  logic [3:0]  delay = 4'h8;
  logic [63:0] rx;
  fosc_exp_s   ex;
  fosc_exp_s   st_q[$];
  logic [63:0] rd_q[$];
  int n_fail = 0, n_tests = 0, seed = 32'h6940b20e;
  int i;
  logic [31:0] a;
  localparam logic [31:0] CTL [3] = '{32'h0642, 32'h1644, 32'h1664};
  localparam logic [2:0]  CMD [3] = '{3'h1, 3'h2, 3'h3};

  always #5 clock = ~clock;

  fosc_ctrl #(.KEY_FIRST(K1), .KEY_SECOND(K2)) DUT (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(reg_rdata_q), .prog_write(prog_write), .prog_addr(prog_addr),
    .prog_data(prog_data), .array_done(array_done), .target_protected(target_protected),
    .target_word(target_word), .flash_start_q(flash_start_q), .flash_cmd_q(flash_cmd_q),
    .flash_addr_q(flash_addr_q), .flash_data_q(flash_data_q),
    .flash_low_power_q(flash_low_power_q), .deep_sleep(deep_sleep), .flash_irq_q(flash_irq_q));
  fosc_flash_model model (.clock(clock), .rst(rst), .flash_start_q(flash_start_q),
    .delay(delay), .array_done(array_done));

  // ********************************************************
  // Compare, bus and closing tasks
  // ********************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= ad;
    rd_q.push_back({m, e});
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  task automatic pw(input logic prot, input logic [15:0] w, input logic [2:0] cmd);
    logic [31:0] pa;
    logic [15:0] pd;
    pa = $random(seed);
    pd = $random(seed);
    if (cmd != 3'h0) st_q.push_back({cmd, pa, pd, 1'b1});
    @(posedge clock);
    prog_write       <= 1'b1;
    prog_addr        <= pa;
    prog_data        <= pd;
    target_protected <= prot;
    target_word      <= w;
    @(posedge clock);
    prog_write <= 1'b0;
  endtask
  task automatic wait_done;
    int k;
    for (k = 0; k < 40 && array_done !== 1'b1; k++) @(posedge clock);
    if (array_done !== 1'b1) chk(32'h0, 32'h1);
    repeat (3) @(posedge clock);
  endtask
  task automatic conclude;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read data and launches are checked against the oldest note in their queue.
  always @(posedge clock) begin
    if (rd_pend) begin
      rx = rd_q.pop_front();
      chk(reg_rdata_q & rx[63:32], rx[31:0]);
    end
    rd_pend <= reg_read;
    if (flash_start_q && st_q.size() == 0) chk(32'h1, 32'h0);
    if (flash_start_q && st_q.size() != 0) begin
      ex = st_q.pop_front();
      chk({29'h0, flash_cmd_q}, {29'h0, ex.cmd});
      chk(flash_addr_q, ex.adr);
      if (ex.use_d) chk({16'h0, flash_data_q}, {16'h0, ex.dat});
    end
  end

  initial begin
    #100us;
    n_fail++;
    conclude();
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(8'h10, 32'hfffd_ffff, 32'h0000_0080);
    rd(8'h0c, 32'hffff_ffff, 32'h0);
    rd(8'hfc, 32'hffff_ffff, 32'h0);
    wr(8'h10, 32'h0000_0042);
    rd(8'h10, 32'h0000_00c0, 32'h0000_0080);
    wr(8'h04, K1);
    wr(8'h04, K2);
    rd(8'h04, 32'hffff_ffff, 32'h0);
    rd(8'h10, 32'hfffd_ffff, 32'h0000_0002);
    wr(8'h08, K1);
    wr(8'h08, K2);
    rd(8'h08, 32'hffff_ffff, 32'h0);
    rd(8'h10, 32'h0000_0200, 32'h0000_0200);
    $display("lock and key checks done");
    for (i = 0; i < 3; i++) begin
      a = $random(seed);
      wr(8'h14, a);
      st_q.push_back({CMD[i], a, 16'h0, 1'b0});
      wr(8'h10, CTL[i]);
      rd(8'h0c, 32'h0000_0001, 32'h1);
      wait_done();
      rd(8'h0c, 32'h0000_003f, 32'h20);
      rd(8'h10, 32'h0000_0041, 32'h0);
      chk({31'h0, flash_irq_q}, (i > 0) ? 32'h1 : 32'h0);
      wr(8'h0c, 32'h20);
      rd(8'h0c, 32'h0000_003f, 32'h0);
      chk({31'h0, flash_irq_q}, 32'h0);
    end
    wr(8'h10, 32'h0);
    wr(8'h10, 32'h0060);
    rd(8'h10, 32'h0000_0240, 32'h0);
    $display("erase checks done");
    delay <= 4'h0;
    wr(8'h10, 32'h0401);
    pw(1'b0, 16'hffff, 3'h4);
    wait_done();
    rd(8'h0c, 32'hffff_ffff, 32'h20);
    chk({31'h0, flash_irq_q}, 32'h0);
    wr(8'h0c, 32'h20);
    pw(1'b0, 16'h1234, 3'h0);
    rd(8'h0c, 32'hffff_ffff, 32'h04);
    chk({31'h0, flash_irq_q}, 32'h1);
    wr(8'h0c, 32'h04);
    pw(1'b1, 16'h0000, 3'h0);
    rd(8'h0c, 32'hffff_ffff, 32'h10);
    chk({31'h0, flash_irq_q}, 32'h1);
    wr(8'h0c, 32'h14);
    rd(8'h0c, 32'hffff_ffff, 32'h0);
    wr(8'h08, K1);
    wr(8'h08, K2);
    wr(8'h10, 32'h0210);
    pw(1'b0, 16'hffff, 3'h5);
    wait_done();
    wr(8'h0c, 32'h20);
    wr(8'h10, 32'h0081);
    pw(1'b0, 16'hffff, 3'h0);
    rd(8'h0c, 32'hffff_ffff, 32'h0);
    $display("program checks done");
    wr(8'h10, 32'h0002_0080);
    deep_sleep <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, flash_low_power_q}, 32'h1);
    wr(8'h10, 32'h0000_0080);
    repeat (3) @(posedge clock);
    chk({31'h0, flash_low_power_q}, 32'h0);
    chk(st_q.size(), 32'h0);
    $display("low power checks done");
    conclude();
  end
endmodule
